//--- hw/fbldm_pkg.sv
// package: protocol codes, timing constants and carrier structs for the fieldbus loss watchdog
package fbldm_pkg;

  typedef enum logic [1:0] {
    proto_enip,
    proto_mbtcp,
    proto_pnio,
    proto_dp
  } fbldm_proto_type;

  // clock rate and timeout units
  localparam int unsigned clk_hz = 50000000;
  localparam int unsigned timeout_unit_ms = 1;
  localparam int unsigned tick_cycles = clk_hz / 1000 * timeout_unit_ms;
  localparam int tick_width = 16;
  localparam int timeout_width = 16;
  localparam logic [timeout_width-1:0] default_timeout_ms = 16'h07d0;
  localparam logic [tick_width-1:0] tick_last = tick_width'(tick_cycles - 1);

  // per-protocol link activity seen by the watchdog
  typedef struct packed {
    logic conn_established;
    logic conn_timed_out;
    logic io_write_seen;
    logic ar_established;
    logic ar_lost;
    logic dp_data_exchange;
    logic ar_open_request;
    logic ar_same_controller;
  } fbldm_link_type;

  // degraded-mode outputs towards the rest of the coupler
  typedef struct packed {
    logic degraded;
    logic operational;
    logic fieldbus_ports_enable;
    logic service_port_enable;
    logic instances_degraded;
    logic resume_commands;
  } fbldm_status_type;

endpackage

//--- hw/fbldm_watchdog.sv
// fieldbus loss watchdog with degraded mode and optional auto-reset
//
// What this block does
// - EtherNet/IP owner connection timeout declares loss
// - Modbus TCP: no I/O writes declares loss
// - PROFINET AR closed declares loss; one AR per controller
// - PROFIBUS-DP loss timeout expiry declares loss
// - on loss stay operational, enter degraded
// - tool link loss never enters degraded
// - fieldbus and service ports stay active
// - instances degrade: local control or fallback
// - auto-reset leaves degraded on restored link
// - without auto-reset, only restart leaves degraded
// - after auto exit resume active commands
`timescale 1ns/1ps
`default_nettype none

module fbldm_watchdog #(
  parameter int tick_cycles = fbldm_pkg::tick_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // configuration
  input wire fbldm_pkg::fbldm_proto_type protocol,
  input wire logic [fbldm_pkg::timeout_width-1:0] loss_timeout_ms,
  input wire logic auto_reset_enable,
  input wire logic restart_command,
  // link activity from the protocol stacks
  input wire fbldm_pkg::fbldm_link_type link,
  // tool sessions, accepted but deliberately not supervised
  input wire logic configuration_tool_active,
  input wire logic maintenance_web_tool_active,
  // per instance local-control capability
  input wire logic [7:0] instance_local_control,
  // status and instance control
  output logic ar_accept,
  output fbldm_pkg::fbldm_status_type status,
  output logic [7:0] instance_follow_local,
  output logic [7:0] instance_fallback,
  output logic comm_lost
);

  // the tick counter runs free, so loss lands between one tick short of the timeout and the timeout itself
  localparam int tick_width = fbldm_pkg::tick_width;
  localparam logic [tick_width-1:0] tick_last = tick_width'(tick_cycles - 1);

  typedef enum logic [1:0] {
    st_normal,
    st_degraded
  } fbldm_state_type;

  // restart arrives from software on the same clock; link from stack logic on the same clock
  fbldm_state_type state;
  fbldm_state_type next_state;
  logic [fbldm_pkg::tick_width-1:0] tick_count;
  logic [fbldm_pkg::tick_width-1:0] next_tick_count;
  logic [fbldm_pkg::timeout_width-1:0] loss_count;
  logic [fbldm_pkg::timeout_width-1:0] next_loss_count;
  logic ar_held;
  logic next_ar_held;
  logic lost;
  logic next_lost;
  logic ms_tick;
  logic healthy;
  logic ar_accept_r;
  logic next_ar_accept;
  fbldm_pkg::fbldm_status_type next_status;
  logic [7:0] next_follow_local;
  logic [7:0] next_fallback;
  // the tool session ports stay unread: a dropped tool session must never degrade the island

  // healthy means the selected link shows qualifying controller activity this cycle
  function automatic logic link_healthy(input fbldm_pkg::fbldm_proto_type p, input fbldm_pkg::fbldm_link_type l);
    case (p)
      fbldm_pkg::proto_enip: link_healthy = l.conn_established && !l.conn_timed_out;
      fbldm_pkg::proto_mbtcp: link_healthy = l.io_write_seen;
      fbldm_pkg::proto_pnio: link_healthy = l.ar_established && !l.ar_lost;
      fbldm_pkg::proto_dp: link_healthy = l.dp_data_exchange;
      default: link_healthy = 1'b0;
    endcase
  endfunction

  // decoded in several places, so kept in one spot
  function automatic logic is_degraded(input fbldm_state_type s);
    is_degraded = (s == st_degraded);
  endfunction

  always_comb
  begin
    healthy = link_healthy(protocol, link);
    ms_tick = (tick_count == tick_last);
    next_tick_count = ms_tick ? '0 : tick_count + 1'b1;
    next_loss_count = loss_count;
    next_lost = lost;
    // any qualifying activity restarts the count; loss only after an unbroken timeout
    if (healthy)
    begin
      next_loss_count = '0;
      next_lost = 1'b0;
    end
    else if (ms_tick && !lost)
    begin
      // a timeout of zero behaves like a timeout of one
      if (loss_count + 1'b1 >= loss_timeout_ms)
        next_lost = 1'b1;
      else
        next_loss_count = loss_count + 1'b1;
    end
  end

  // one AR per controller: a second request from the same controller is refused
  always_comb
  begin
    next_ar_held = ar_held;
    next_ar_accept = 1'b0;
    if (protocol == fbldm_pkg::proto_pnio)
    begin
      if (link.ar_lost)
        next_ar_held = 1'b0;
      if (link.ar_open_request)
      begin
        next_ar_accept = !(ar_held && link.ar_same_controller);
        if (next_ar_accept)
          next_ar_held = 1'b1;
      end
    end
    else
      next_ar_held = 1'b0;
  end

  // tool activity never feeds the loss decision
  always_comb
  begin
    next_state = state;
    case (state)
      st_normal:
        // restart outranks a loss seen in the same cycle; a loss still standing re-enters one cycle later
        if (lost && !restart_command)
          next_state = st_degraded;
      st_degraded:
        if (restart_command)
          next_state = st_normal;
        else if (auto_reset_enable && healthy)
          next_state = st_normal;
      default:
        next_state = st_normal;
    endcase
    next_status.degraded = is_degraded(next_state);
    next_status.operational = 1'b1;
    next_status.fieldbus_ports_enable = 1'b1;
    next_status.service_port_enable = 1'b1;
    next_status.instances_degraded = is_degraded(next_state);
    // commands are honoured at once after exit, with no re-arm step; load may energise
    next_status.resume_commands = !is_degraded(next_state);
  end

  // every instance chooses on its own, so an island with mixed instances splits cleanly
  for (genvar i = 0; i < $bits(instance_local_control); i++)
  begin : g_inst
    assign next_follow_local[i] = next_status.degraded && instance_local_control[i];
    assign next_fallback[i] = next_status.degraded && !instance_local_control[i];
  end

  // loss timer; comm_lost mirrors lost so the pin comes straight from its own flop
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tick_count <= '0;
      loss_count <= '0;
      lost <= 1'b0;
      comm_lost <= 1'b0;
    end
    else
    begin
      tick_count <= next_tick_count;
      loss_count <= next_loss_count;
      lost <= next_lost;
      comm_lost <= next_lost;
    end
  end

  // application relation bookkeeping; the accept answer stands for one cycle per request
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ar_held <= 1'b0;
      ar_accept_r <= 1'b0;
    end
    else
    begin
      ar_held <= next_ar_held;
      ar_accept_r <= next_ar_accept;
    end
  end

  // mode and outputs; all come from next values so they change on the same edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= st_normal;
      status <= '{degraded: 1'b0, operational: 1'b1, fieldbus_ports_enable: 1'b1,
                  service_port_enable: 1'b1, instances_degraded: 1'b0, resume_commands: 1'b1};
      instance_follow_local <= '0;
      instance_fallback <= '0;
    end
    else
    begin
      state <= next_state;
      status <= next_status;
      instance_follow_local <= next_follow_local;
      instance_fallback <= next_fallback;
    end
  end

  assign ar_accept = ar_accept_r;

endmodule

`default_nettype wire

//--- test/fbldm_watchdog_chk.sv
// checker for the fieldbus loss watchdog
`timescale 1ns/1ps
`default_nettype none
module fbldm_watchdog_chk #(
  parameter int tick_cycles = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // inputs
  input wire fbldm_pkg::fbldm_proto_type protocol,
  input wire logic auto_reset_enable,
  input wire logic restart_command,
  input wire fbldm_pkg::fbldm_link_type link,
  input wire logic [7:0] instance_local_control,
  // outputs
  input wire fbldm_pkg::fbldm_status_type status,
  input wire logic [7:0] instance_follow_local,
  input wire logic comm_lost
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_stay_oper: assert property (status.operational && status.fieldbus_ports_enable && status.service_port_enable)
    else $error("ports or operation dropped");
  a_degr_entry: assert property ($rose(comm_lost) && !restart_command |=> status.degraded)
    else $error("no degraded after loss");
  a_resume_cmds: assert property (status.resume_commands != status.degraded)
    else $error("resume wrong");
  a_local_follow: assert property (status.degraded && $stable(instance_local_control)
    |-> instance_follow_local == instance_local_control)
    else $error("local follow wrong");
  a_mb_clear: assert property (protocol == fbldm_pkg::proto_mbtcp && link.io_write_seen |=> !comm_lost)
    else $error("loss kept after write");
  a_auto_exit: assert property (status.degraded && auto_reset_enable && protocol == fbldm_pkg::proto_mbtcp && link.io_write_seen
    |=> !status.degraded)
    else $error("no auto exit");
  a_hold_degr: assert property (!auto_reset_enable && !restart_command && status.degraded |=> status.degraded)
    else $error("degraded left");
  a_restart_exit: assert property (restart_command |=> !status.degraded)
    else $error("restart ignored");
endmodule
bind fbldm_watchdog fbldm_watchdog_chk #(.tick_cycles(tick_cycles)) chk (.*);
`default_nettype wire

//--- test/fbldm_plc_model.sv
// controller model: cyclic i/o writes while enabled
`timescale 1ns/1ps
`default_nettype none
module fbldm_plc_model (
  input wire logic mclk,
  input wire logic en,
  output logic wr
);
  logic ph = 1'b0;
  initial wr = 1'b0;
  // a write every other cycle keeps the link healthy
  always @(posedge mclk)
  begin
    ph <= ~ph;
    wr <= #2 en & ph;
  end
endmodule
`default_nettype wire

//--- test/fbldm_watchdog_tb.sv
// self-checking bench for the fieldbus loss watchdog
`timescale 1ns/1ps
`default_nettype none
module fbldm_watchdog_tb;
  logic mclk = 0, sys_rst = 1, auto = 0, rcmd = 0, pen = 0, tool = 0, wr, acc, lost;
  logic [7:0] lnk = 8'h00, loc = 8'ha5, fol, fb;
  fbldm_pkg::fbldm_proto_type proto = fbldm_pkg::proto_mbtcp;
  fbldm_pkg::fbldm_status_type st;
  int mismatches = 0, checked = 0;
  always #10 mclk = ~mclk;
  fbldm_plc_model plc (.mclk(mclk), .en(pen), .wr(wr));
  fbldm_watchdog #(.tick_cycles(4)) uut (.mclk(mclk), .sys_rst(sys_rst), .protocol(proto),
    .loss_timeout_ms(16'h0003), .auto_reset_enable(auto), .restart_command(rcmd),
    .link(lnk | {2'h0, wr, 5'h00}), .configuration_tool_active(tool), .maintenance_web_tool_active(tool),
    .instance_local_control(loc), .ar_accept(acc), .status(st), .instance_follow_local(fol),
    .instance_fallback(fb), .comm_lost(lost));
  task automatic test_done;
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // loss on one protocol, then recovery by link or by restart
  task automatic loss(input fbldm_pkg::fbldm_proto_type p, input logic [7:0] h, input logic a);
    int n;
    n = 0;
    proto = p;
    auto = a;
    lnk = h;
    pen = (p == fbldm_pkg::proto_mbtcp);
    tool = 0;
    cyc(20);
    chk(st, 8'h1d);
    tool = 1;
    lnk = 8'h00;
    pen = 0;
    while (lost !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, n >= 7 && n <= 13}, 8'h01);
    cyc(1);
    chk(st, 8'h3e);
    chk(fol, 8'ha5);
    chk(fb, 8'h5a);
    loc = 8'h0f;
    cyc(1);
    loc = 8'ha5;
    chk(fol, 8'h0f);
    chk(fb, 8'hf0);
    lnk = h;
    pen = (p == fbldm_pkg::proto_mbtcp);
    cyc(4);
    chk(st, a ? 8'h1d : 8'h3e);
    rcmd = 1;
    cyc(1);
    rcmd = 0;
    cyc(1);
    chk(st, 8'h1d);
  endtask
  // one application relation per controller; another controller may still open its own
  task automatic ar_one;
    proto = fbldm_pkg::proto_pnio;
    lnk = 8'h13;
    cyc(1);
    lnk = 8'h11;
    chk({7'h00, acc}, 8'h01);
    cyc(1);
    lnk = 8'h13;
    cyc(1);
    lnk = 8'h11;
    chk({7'h00, acc}, 8'h00);
    cyc(1);
    lnk = 8'h12;
    cyc(1);
    chk({7'h00, acc}, 8'h01);
  endtask
  initial
  begin
    cyc(5);
    sys_rst = 0;
    loss(fbldm_pkg::proto_mbtcp, 8'h00, 1);
    loss(fbldm_pkg::proto_mbtcp, 8'h00, 0);
    loss(fbldm_pkg::proto_enip, 8'h80, 0);
    loss(fbldm_pkg::proto_pnio, 8'h11, 1);
    loss(fbldm_pkg::proto_dp, 8'h04, 1);
    ar_one;
    test_done;
  end
  initial
  begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
